// *** hw/fcomb_pkg.sv ***
// fcomb_pkg: constants shared by the frequency reference combiner
// assumes frequencies in 0.01 Hz steps, input percentages in 0.1 % steps and range percent in 1 % steps
package fcomb_pkg;

    localparam int FREQ_W    = 16;
    localparam int VAL_W     = 24;
    localparam int PCT_W     = 12;
    localparam int SRC_W     = 4;
    localparam int RPCT_W    = 8;
    localparam int MUL_W     = 48;

    localparam int PCT_FULL  = 1000;
    localparam int RPCT_UNIT = 100;
    localparam int RPCT_MAX  = 150;
    localparam int HZ_SCALE  = 100;

    // source channel codes
    localparam logic [3:0] SRC_DIG_NONRET = 4'h0;
    localparam logic [3:0] SRC_DIG_RET    = 4'h1;
    localparam logic [3:0] SRC_ANALOG_ONE = 4'h2;
    localparam logic [3:0] SRC_ANALOG_TWO = 4'h3;
    localparam logic [3:0] SRC_RESERVED   = 4'h4;
    localparam logic [3:0] SRC_PULSE      = 4'h5;
    localparam logic [3:0] SRC_MSTAGE     = 4'h6;
    localparam logic [3:0] SRC_SEQUENCER  = 4'h7;
    localparam logic [3:0] SRC_PID        = 4'h8;
    localparam logic [3:0] SRC_HOST       = 4'h9;
    localparam logic [3:0] SRC_DEFAULT    = SRC_DIG_NONRET;

    // ones digit of reference_combine_select
    localparam logic [3:0] SEL_MAIN       = 4'h0;
    localparam logic [3:0] SEL_COMBINED   = 4'h1;
    localparam logic [3:0] SEL_SW_X_Y     = 4'h2;
    localparam logic [3:0] SEL_SW_X_COMB  = 4'h3;
    localparam logic [3:0] SEL_SW_Y_COMB  = 4'h4;

    // tens digit of reference_combine_select
    localparam logic [3:0] REL_SUM        = 4'h0;
    localparam logic [3:0] REL_DIFF       = 4'h1;
    localparam logic [3:0] REL_MAXABS     = 4'h2;
    localparam logic [3:0] REL_MINABS     = 4'h3;
    localparam logic [3:0] REL_PRODUCT    = 4'h4;

    localparam int ONES_LSB = 0;
    localparam int TENS_LSB = 4;

    // aux_range_reference
    localparam logic REF_MAX_FREQ = 1'b0;
    localparam logic REF_MAIN     = 1'b1;

    localparam logic [7:0] COMBINE_SELECT_DEFAULT = 8'h00;
    localparam logic [7:0] RANGE_PERCENT_DEFAULT  = 8'h00;

endpackage

// *** hw/fcomb_chan_sel.sv ***
// fcomb_chan_sel: decodes one source channel code into a frequency value
// assumes every channel front end presents a settled value each cycle
`timescale 1ns/1ps
module fcomb_chan_sel
    import fcomb_pkg::*;
#(
    parameter int FW = FREQ_W,
    parameter int PW = PCT_W,
    parameter int VW = VAL_W
)(
    input  wire logic [SRC_W-1:0]  code_i,
    input  wire logic [FW-1:0]     max_freq_i,
    input  wire logic [FW-1:0]     dig_nonret_i,
    input  wire logic [FW-1:0]     dig_ret_i,
    input  wire logic signed [PW-1:0] ai_one_i,
    input  wire logic signed [PW-1:0] ai_two_i,
    input  wire logic signed [PW-1:0] pulse_i,
    input  wire logic [FW-1:0]     mstage_i,
    input  wire logic [FW-1:0]     seq_i,
    input  wire logic [FW-1:0]     pid_i,
    input  wire logic [FW-1:0]     host_i,
    output logic signed [VW-1:0]   value_o,
    output logic signed [PW-1:0]   pct_o,
    output logic                   is_analog_o,
    output logic                   is_digital_o
);

    // percentage of full scale to frequency
    function automatic logic signed [VW-1:0] pct_to_freq(
        input logic signed [PW-1:0] pct,
        input logic [FW-1:0]        mx
    );
        logic signed [MUL_W-1:0] prod;
        prod = MUL_W'(pct) * $signed({1'b0, mx});
        return VW'(prod / PCT_FULL);
    endfunction

    function automatic logic signed [VW-1:0] ext(input logic [FW-1:0] f);
        return $signed({{(VW-FW){1'b0}}, f});
    endfunction

    ////////////////////////////////////////////////////////////////////
    assign is_analog_o  = (code_i == SRC_ANALOG_ONE) || (code_i == SRC_ANALOG_TWO)
                       || (code_i == SRC_PULSE);
    assign is_digital_o = (code_i == SRC_DIG_NONRET) || (code_i == SRC_DIG_RET);

    always_comb
    begin
        value_o = '0;
        pct_o   = '0;
        case (code_i)
            SRC_DIG_NONRET: value_o = ext(dig_nonret_i);
            SRC_DIG_RET:    value_o = ext(dig_ret_i);
            SRC_ANALOG_ONE:
            begin
                pct_o   = ai_one_i;
                value_o = pct_to_freq(ai_one_i, max_freq_i);
            end
            SRC_ANALOG_TWO:
            begin
                pct_o   = ai_two_i;
                value_o = pct_to_freq(ai_two_i, max_freq_i);
            end
            SRC_PULSE:
            begin
                pct_o   = pulse_i;
                value_o = pct_to_freq(pulse_i, max_freq_i);
            end
            SRC_MSTAGE:     value_o = ext(mstage_i);
            SRC_SEQUENCER:  value_o = ext(seq_i);
            SRC_PID:        value_o = ext(pid_i);
            SRC_HOST:       value_o = ext(host_i);
            default:        value_o = '0;
        endcase
    end

endmodule

// *** hw/fcomb_top.sv ***
// fcomb_top: selects and combines main source X and auxiliary source Y
// assumes settings are static or change between update ticks
// Summary of operation
// - aux code 0..9: digital, retentive, analog x2, reserved, pulse, stages, sequencer, PID, host
// - main code 9 takes the host-written frequency value
// - switched-in aux behaves exactly as main would with that code
// - superimposed digital aux ignores preset, up/down trims from present value
// - superimposed analog/pulse aux: 100 % input equals full aux range
// - range reference 0 is maximum frequency, 1 is main value
// - aux range is 0..150 % of the selected reference
// - max-referenced range fixed, main-referenced range follows main
// - aux range scaling applies only for selection digits 1, 3, 4
// - ones digit picks arrangement, tens digit picks relation, both default 0
// - digit 0: target is main alone
// - digit 1: target is combined result
// - digit 2: main while switch inactive, aux while active
// - digit 3: main while switch inactive, combined while active
// - digit 4: aux while switch inactive, combined while active
// - relation 0: sum
// - relation 1: main minus aux
// - relation 2: value with larger magnitude
// - relation 3: value with smaller magnitude
// - relation 4: product
`timescale 1ns/1ps
module fcomb_top
    import fcomb_pkg::*;
#(
    parameter int FW      = FREQ_W,
    parameter int PW      = PCT_W,
    parameter int VW      = VAL_W,
    parameter int TRIM_STEP = 1
)(
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 tick_i,
    input  wire logic [SRC_W-1:0]     main_source_select_i,
    input  wire logic [SRC_W-1:0]     aux_source_select_i,
    input  wire logic                 aux_range_reference_i,
    input  wire logic [RPCT_W-1:0]    aux_range_percent_i,
    input  wire logic [7:0]           reference_combine_select_i,
    input  wire logic [FW-1:0]        maximum_output_frequency_i,
    input  wire logic [FW-1:0]        digital_nonret_i,
    input  wire logic [FW-1:0]        digital_ret_i,
    input  wire logic                 trim_up_i,
    input  wire logic                 trim_down_i,
    input  wire logic signed [PW-1:0] analog_input_one_i,
    input  wire logic signed [PW-1:0] analog_input_two_i,
    input  wire logic signed [PW-1:0] pulse_input_i,
    input  wire logic [FW-1:0]        multistage_freq_i,
    input  wire logic [FW-1:0]        sequencer_freq_i,
    input  wire logic [FW-1:0]        pid_freq_i,
    input  wire logic [FW-1:0]        host_freq_i,
    input  wire logic                 source_switch_i,
    output logic [FW-1:0]             target_freq_o,
    output logic [FW-1:0]             aux_range_o,
    output logic                      target_valid_o
);

    function automatic logic signed [VW-1:0] abs_v(input logic signed [VW-1:0] v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic logic [FW-1:0] clamp_f(
        input logic signed [VW-1:0] v,
        input logic [FW-1:0]        mx
    );
        if (v < 0)
            return '0;
        else if (v > $signed({{(VW-FW){1'b0}}, mx}))
            return mx;
        else
            return v[FW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // channel decode, one decoder instance per source (u_main_sel, u_aux_sel)
    logic signed [VW-1:0] main_val;
    logic signed [VW-1:0] aux_chan_val;
    logic signed [PW-1:0] aux_pct;
    logic                 aux_is_analog;
    logic                 aux_is_digital;

    fcomb_chan_sel #(.FW(FW), .PW(PW), .VW(VW)) u_main_sel (
        .code_i       (main_source_select_i),
        .max_freq_i   (maximum_output_frequency_i),
        .dig_nonret_i (digital_nonret_i),
        .dig_ret_i    (digital_ret_i),
        .ai_one_i     (analog_input_one_i),
        .ai_two_i     (analog_input_two_i),
        .pulse_i      (pulse_input_i),
        .mstage_i     (multistage_freq_i),
        .seq_i        (sequencer_freq_i),
        .pid_i        (pid_freq_i),
        .host_i       (host_freq_i),
        .value_o      (main_val),
        .pct_o        (),
        .is_analog_o  (),
        .is_digital_o ()
    );

    fcomb_chan_sel #(.FW(FW), .PW(PW), .VW(VW)) u_aux_sel (
        .code_i       (aux_source_select_i),
        .max_freq_i   (maximum_output_frequency_i),
        .dig_nonret_i (digital_nonret_i),
        .dig_ret_i    (digital_ret_i),
        .ai_one_i     (analog_input_one_i),
        .ai_two_i     (analog_input_two_i),
        .pulse_i      (pulse_input_i),
        .mstage_i     (multistage_freq_i),
        .seq_i        (sequencer_freq_i),
        .pid_i        (pid_freq_i),
        .host_i       (host_freq_i),
        .value_o      (aux_chan_val),
        .pct_o        (aux_pct),
        .is_analog_o  (aux_is_analog),
        .is_digital_o (aux_is_digital)
    );

    ////////////////////////////////////////////////////////////////////
    // selector digits and auxiliary range
    wire [3:0] ones_w = reference_combine_select_i[ONES_LSB +: 4];
    wire [3:0] tens_w = reference_combine_select_i[TENS_LSB +: 4];
    wire       superimposed_w = (ones_w == SEL_COMBINED) || (ones_w == SEL_SW_X_COMB)
                             || (ones_w == SEL_SW_Y_COMB);

    wire [RPCT_W-1:0] rpct_w = (aux_range_percent_i > RPCT_W'(RPCT_MAX))
                             ? RPCT_W'(RPCT_MAX) : aux_range_percent_i;
    // main-referenced range is combinational so it tracks main directly
    wire logic signed [VW-1:0] range_ref_w = (aux_range_reference_i == REF_MAIN)
                             ? abs_v(main_val)
                             : $signed({{(VW-FW){1'b0}}, maximum_output_frequency_i});
    wire logic signed [MUL_W-1:0] range_prod_w = MUL_W'(range_ref_w) * $signed({1'b0, rpct_w});
    wire logic signed [VW-1:0] range_w = VW'(range_prod_w / RPCT_UNIT);
    wire logic signed [MUL_W-1:0] aux_an_prod_w = MUL_W'(aux_pct) * MUL_W'(range_w);
    wire logic signed [VW-1:0] aux_an_val_w = VW'(aux_an_prod_w / PCT_FULL);

    ////////////////////////////////////////////////////////////////////
    // trim offset for superimposed digital aux, starts at zero
    logic signed [VW-1:0] trim_q;
    logic signed [VW-1:0] trim_d;
    wire trim_active_w = superimposed_w && aux_is_digital;

    always_comb
    begin
        trim_d = trim_q;
        if (!trim_active_w)
            trim_d = '0;
        else if (trim_up_i && !trim_down_i && trim_q < range_w)
            trim_d = trim_q + VW'(TRIM_STEP);
        else if (trim_down_i && !trim_up_i && trim_q > -range_w)
            trim_d = trim_q - VW'(TRIM_STEP);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            trim_q <= '0;
        else
            trim_q <= trim_d;
    end

    ////////////////////////////////////////////////////////////////////
    // auxiliary value and combination
    wire logic signed [VW-1:0] aux_val_w = !superimposed_w ? aux_chan_val
                             : aux_is_analog  ? aux_an_val_w
                             : aux_is_digital ? trim_q
                             : aux_chan_val;
    wire logic signed [MUL_W-1:0] prod_w = MUL_W'(main_val) * MUL_W'(aux_val_w);
    wire main_bigger_w = abs_v(main_val) >= abs_v(aux_val_w);

    logic signed [VW-1:0] comb_raw;
    always_comb
    begin
        case (tens_w)
            REL_SUM:     comb_raw = main_val + aux_val_w;
            REL_DIFF:    comb_raw = main_val - aux_val_w;
            REL_MAXABS:  comb_raw = main_bigger_w ? main_val : aux_val_w;
            REL_MINABS:  comb_raw = main_bigger_w ? aux_val_w : main_val;
            REL_PRODUCT: comb_raw = VW'(prod_w / HZ_SCALE);
            default:     comb_raw = main_val + aux_val_w;
        endcase
    end

    wire [FW-1:0] main_cl_w = clamp_f(main_val, maximum_output_frequency_i);
    wire [FW-1:0] aux_cl_w  = clamp_f(aux_val_w, maximum_output_frequency_i);
    wire [FW-1:0] comb_cl_w = clamp_f(comb_raw, maximum_output_frequency_i);

    logic [FW-1:0] target_sel;
    always_comb
    begin
        case (ones_w)
            SEL_MAIN:      target_sel = main_cl_w;
            SEL_COMBINED:  target_sel = comb_cl_w;
            SEL_SW_X_Y:    target_sel = source_switch_i ? aux_cl_w : main_cl_w;
            SEL_SW_X_COMB: target_sel = source_switch_i ? comb_cl_w : main_cl_w;
            SEL_SW_Y_COMB: target_sel = source_switch_i ? comb_cl_w : aux_cl_w;
            default:       target_sel = main_cl_w;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // output registers updated on each tick
    logic [FW-1:0] target_q;
    logic [FW-1:0] range_q;
    logic          valid_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            target_q <= '0;
            range_q  <= '0;
            valid_q  <= 1'b0;
        end
        else
        begin
            valid_q <= tick_i;
            if (tick_i)
            begin
                target_q <= target_sel;
                range_q  <= clamp_f(range_w, {FW{1'b1}});
            end
        end
    end

    assign target_freq_o  = target_q;
    assign aux_range_o    = range_q;
    assign target_valid_o = valid_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_main_only;
        @(posedge clk_i) disable iff (!rstn_i)
        (tick_i && ones_w == SEL_MAIN) |=> (target_q == $past(main_cl_w));
    endproperty
    a_main_only: assert property (p_main_only) else $error("main-only target wrong");

    property p_combined;
        @(posedge clk_i) disable iff (!rstn_i)
        (tick_i && ones_w == SEL_COMBINED) |=> (target_q == $past(comb_cl_w));
    endproperty
    a_combined: assert property (p_combined) else $error("combined target wrong");

    property p_sw_xy;
        @(posedge clk_i) disable iff (!rstn_i)
        (tick_i && ones_w == SEL_SW_X_Y)
            |=> (target_q == ($past(source_switch_i) ? $past(aux_cl_w) : $past(main_cl_w)));
    endproperty
    a_sw_xy: assert property (p_sw_xy) else $error("x/y switchover wrong");

    property p_sw_xc;
        @(posedge clk_i) disable iff (!rstn_i)
        (tick_i && ones_w == SEL_SW_X_COMB)
            |=> (target_q == ($past(source_switch_i) ? $past(comb_cl_w) : $past(main_cl_w)));
    endproperty
    a_sw_xc: assert property (p_sw_xc) else $error("x/comb switchover wrong");

    property p_sw_yc;
        @(posedge clk_i) disable iff (!rstn_i)
        (tick_i && ones_w == SEL_SW_Y_COMB)
            |=> (target_q == ($past(source_switch_i) ? $past(comb_cl_w) : $past(aux_cl_w)));
    endproperty
    a_sw_yc: assert property (p_sw_yc) else $error("y/comb switchover wrong");

    property p_sum;
        @(posedge clk_i) disable iff (!rstn_i)
        (tens_w == REL_SUM) |-> (comb_raw == main_val + aux_val_w);
    endproperty
    a_sum: assert property (p_sum) else $error("sum relation wrong");

    property p_diff;
        @(posedge clk_i) disable iff (!rstn_i)
        (tens_w == REL_DIFF) |-> (comb_raw == main_val - aux_val_w);
    endproperty
    a_diff: assert property (p_diff) else $error("difference relation wrong");

    property p_maxabs;
        @(posedge clk_i) disable iff (!rstn_i)
        (tens_w == REL_MAXABS) |-> (abs_v(comb_raw) >= abs_v(main_val)
                                  && abs_v(comb_raw) >= abs_v(aux_val_w));
    endproperty
    a_maxabs: assert property (p_maxabs) else $error("larger-magnitude relation wrong");

    property p_minabs;
        @(posedge clk_i) disable iff (!rstn_i)
        (tens_w == REL_MINABS) |-> (abs_v(comb_raw) <= abs_v(main_val)
                                  && abs_v(comb_raw) <= abs_v(aux_val_w));
    endproperty
    a_minabs: assert property (p_minabs) else $error("smaller-magnitude relation wrong");

    property p_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        !tick_i |=> $stable(target_q);
    endproperty
    a_hold: assert property (p_hold) else $error("target moved without tick");

    property p_limit;
        @(posedge clk_i) disable iff (!rstn_i)
        valid_q |-> (target_q <= $past(maximum_output_frequency_i));
    endproperty
    a_limit: assert property (p_limit) else $error("target above maximum");

    property p_host;
        @(posedge clk_i) disable iff (!rstn_i)
        (main_source_select_i == SRC_HOST) |-> (main_val == $signed({{(VW-FW){1'b0}}, host_freq_i}));
    endproperty
    a_host: assert property (p_host) else $error("host source not used");

    property p_reserved;
        @(posedge clk_i) disable iff (!rstn_i)
        (aux_source_select_i == SRC_RESERVED) |-> (aux_chan_val == 0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved aux code not zero");

    property p_no_scale;
        @(posedge clk_i) disable iff (!rstn_i)
        !superimposed_w |-> (aux_val_w == aux_chan_val) ##1 (trim_q == 0);
    endproperty
    a_no_scale: assert property (p_no_scale) else $error("aux scaled outside superposition");

    property p_trim;
        @(posedge clk_i) disable iff (!rstn_i)
        (trim_active_w && trim_up_i && !trim_down_i && trim_q < range_w)
            |=> (trim_q == $past(trim_q) + VW'(TRIM_STEP)) [*1];
    endproperty
    a_trim: assert property (p_trim) else $error("trim did not step up");

    c_sw_active: cover property (@(posedge clk_i) disable iff (!rstn_i)
        tick_i && ones_w == SEL_SW_X_Y && source_switch_i);
    c_product:   cover property (@(posedge clk_i) disable iff (!rstn_i)
        tick_i && ones_w == SEL_COMBINED && tens_w == REL_PRODUCT);
    c_analog:    cover property (@(posedge clk_i) disable iff (!rstn_i)
        superimposed_w && aux_is_analog && aux_range_reference_i == REF_MAIN);
    c_clamp:     cover property (@(posedge clk_i) disable iff (!rstn_i)
        tick_i && comb_raw < 0);

endmodule

// *** tb/fcomb_far_model.sv ***
// fcomb_far_model: channel front ends, keypad, terminals and host link
// assumes shuffle_i is a one-cycle request; values move only then
`timescale 1ns/1ps
module fcomb_far_model
    import fcomb_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 shuffle_i,
    input  wire logic [FREQ_W-1:0]    max_freq_i,
    output logic [FREQ_W-1:0]         dnr_o = '0,
    output logic [FREQ_W-1:0]         dr_o = '0,
    output logic signed [PCT_W-1:0]   a1_o = '0,
    output logic signed [PCT_W-1:0]   a2_o = '0,
    output logic signed [PCT_W-1:0]   pl_o = '0,
    output logic [FREQ_W-1:0]         ms_o = '0,
    output logic [FREQ_W-1:0]         sq_o = '0,
    output logic [FREQ_W-1:0]         pid_o = '0,
    output logic [FREQ_W-1:0]         host_o = '0
);
    // frequencies stay within zero..maximum
    function automatic logic [FREQ_W-1:0] rf();
        return FREQ_W'($urandom % (int'(max_freq_i) + 1));
    endfunction
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        if (shuffle_i)
        begin
            dnr_o  <= rf();
            dr_o   <= rf();
            ms_o   <= rf();
            sq_o   <= rf();
            pid_o  <= rf();
            host_o <= rf();
            a1_o   <= PCT_W'($urandom % 1001);
            a2_o   <= PCT_W'(int'($urandom % 2001) - PCT_FULL);
            pl_o   <= PCT_W'(int'($urandom % 2001) - PCT_FULL);
        end
    end
endmodule

// *** tb/frequency_reference_combiner_tb_top.sv ***
// frequency_reference_combiner_tb_top: scoreboard bench for fcomb_top
// assumes the far side comes from fcomb_far_model; assertions sit in hw
`timescale 1ns/1ps
module frequency_reference_combiner_tb_top
    import fcomb_pkg::*;
;
    typedef struct packed {logic [15:0] tf; logic [15:0] rg; logic sup;} fcomb_exp_s;
    localparam logic [3:0] MAIN_CODES [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    logic               clk = 1'b0, rstn = 1'b0, tick = 1'b0, shuf = 1'b0;
    logic               tu = 1'b0, td = 1'b0, sw = 1'b0, rsel = 1'b0, vld;
    logic [3:0]         msel = '0, asel = '0, mc;
    logic [7:0]         pct = '0, csel = '0;
    logic [15:0]        mx = 16'h1388;
    logic [15:0]        dnr, dr, ms, sq, pidf, host, tf, rg;
    logic signed [11:0] a1, a2, pl;
    int                 error_cnt = 0, num_checks = 0, trim_exp = 0;
    fcomb_exp_s         q[$];
    fcomb_exp_s         me;

    initial forever #50 clk = ~clk;

    fcomb_top dut_u (
        .clk_i(clk), .rstn_i(rstn), .tick_i(tick), .main_source_select_i(msel), .aux_source_select_i(asel),
        .aux_range_reference_i(rsel), .aux_range_percent_i(pct), .reference_combine_select_i(csel),
        .maximum_output_frequency_i(mx), .digital_nonret_i(dnr), .digital_ret_i(dr), .trim_up_i(tu),
        .trim_down_i(td), .analog_input_one_i(a1), .analog_input_two_i(a2), .pulse_input_i(pl),
        .multistage_freq_i(ms), .sequencer_freq_i(sq), .pid_freq_i(pidf), .host_freq_i(host),
        .source_switch_i(sw), .target_freq_o(tf), .aux_range_o(rg), .target_valid_o(vld)
    );
    fcomb_far_model far_u (
        .clk_i(clk), .shuffle_i(shuf), .max_freq_i(mx), .dnr_o(dnr), .dr_o(dr), .a1_o(a1), .a2_o(a2),
        .pl_o(pl), .ms_o(ms), .sq_o(sq), .pid_o(pidf), .host_o(host)
    );
    ////////////////////////////////////////////////////////////
    function automatic int ab(input int v);
        return v < 0 ? -v : v;
    endfunction
    function automatic int pc(input logic [3:0] c);
        return c == 4'h2 ? int'(a1) : (c == 4'h3 ? int'(a2) : int'(pl));
    endfunction
    function automatic int chan(input logic [3:0] c);
        case (c)
            4'h0: return int'(dnr);
            4'h1: return int'(dr);
            4'h2, 4'h3, 4'h5: return pc(c) * int'(mx) / PCT_FULL;
            4'h6: return int'(ms);
            4'h7: return int'(sq);
            4'h8: return int'(pidf);
            4'h9: return int'(host);
            default: return 0;
        endcase
    endfunction
    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // tick with current settings, expected result noted in the queue
    task automatic fire();
        int x, y, r, c, o, t;
        bit s;
        tick <= 1'b1;
        #1;
        o = int'(csel[3:0]);
        s = (o == 1 || o == 3 || o == 4);
        x = chan(msel);
        r = (rsel ? ab(x) : int'(mx)) * (pct > 150 ? 150 : int'(pct)) / RPCT_UNIT;
        if (!s) y = chan(asel);
        else if (asel < 2) y = trim_exp;
        else if (asel == 2 || asel == 3 || asel == 5) y = pc(asel) * r / PCT_FULL;
        else y = chan(asel);
        case (csel[7:4])
            4'h1: c = x - y;
            4'h2: c = ab(x) >= ab(y) ? x : y;
            4'h3: c = ab(x) < ab(y) ? x : y;
            4'h4: c = x * y / HZ_SCALE;
            default: c = x + y;
        endcase
        case (o)
            1: t = c;
            2: t = sw ? y : x;
            3: t = sw ? c : x;
            4: t = sw ? c : y;
            default: t = x;
        endcase
        t = t < 0 ? 0 : (t > int'(mx) ? int'(mx) : t);
        q.push_back('{16'(t), 16'(r), s});
        @(posedge clk);
    endtask
    task automatic shuffle();
        tick <= 1'b0;
        shuf <= 1'b1;
        mx <= 16'(5000 + $urandom % 5001);
        @(posedge clk);
        shuf <= 1'b0;
    endtask
    task automatic rand_cfg(input logic [3:0] m, input int ones, input int tens, input bit swv);
        logic [3:0] a;
        a = 4'($urandom % 10);
        if (a == m) a = 4'((int'(a) + 1) % 10);
        asel <= a;
        rsel <= 1'($urandom % 2);
        pct <= 8'($urandom % 161);
        csel <= {4'(tens), 4'(ones)};
        sw <= swv;
    endtask
    task automatic trim(input int nu, input int nd);
        tick <= 1'b0;
        tu <= 1'b1;
        repeat (nu) @(posedge clk);
        tu <= 1'b0;
        td <= 1'b1;
        repeat (nd) @(posedge clk);
        tu <= 1'b1;
        repeat (3) @(posedge clk);
        tu <= 1'b0;
        td <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(46743));
        repeat (4) @(posedge clk);
        cmp("reset target", 16'h0, tf);
        rstn <= 1'b1;
        for (int i = 0; i < 100; i++)
        begin
            shuffle();
            mc = MAIN_CODES[$urandom % 10];
            msel <= mc;
            rand_cfg(mc, i % 5, (i / 5) % 5, ((i % 50) / 25) == 1);
            fire();
            rand_cfg(msel, $urandom % 6, $urandom % 6, 1'($urandom % 2));
            fire();
        end
        shuffle();
        msel <= 4'h6;
        asel <= 4'h1;
        rsel <= 1'b0;
        pct <= 8'h00;
        csel <= 8'h01;
        fire();
        trim(10, 1);
        fire();
        pct <= 8'h64;
        fire();
        trim(20, 5);
        trim_exp = 15;
        fire();
        tick <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("pending", 16'h0, 16'(q.size()));
        tally_and_finish();
    end
    always @(posedge clk)
    begin
        if (vld === 1'b1)
        begin
            if (q.size() == 0)
                cmp("spare valid", 16'h0, 16'h1);
            else
            begin
                me = q.pop_front();
                cmp("target", me.tf, tf);
                if (me.sup)
                    cmp("range", me.rg, rg);
            end
        end
    end
    // about 360 cycles expected; far more means a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
